//--- shared/aoc_pkg.sv
// Constants shared by the output word and mode control block.
// Assumes a 16-bit word register port and one 25 MHz clock.
package aoc_pkg;

  localparam int unsigned AOC_ADDR_W = 4;
  localparam int unsigned AOC_WORD_W = 16;
  localparam int unsigned AOC_VAL_W  = 8;
  localparam int unsigned AOC_NIN    = 4;

  // Register indices
  localparam logic [3:0] AOC_OFF_OUT0   = 4'h0;
  localparam logic [3:0] AOC_OFF_OUT1   = 4'h1;
  localparam logic [3:0] AOC_OFF_SETUP0 = 4'h2;
  localparam logic [3:0] AOC_OFF_SETUP1 = 4'h3;
  localparam logic [3:0] AOC_OFF_FLT0   = 4'h4;
  localparam logic [3:0] AOC_OFF_IDLE0  = 4'h5;
  localparam logic [3:0] AOC_OFF_FLT1   = 4'h6;
  localparam logic [3:0] AOC_OFF_IDLE1  = 4'h7;
  localparam logic [3:0] AOC_OFF_STATUS = 4'h8;
  localparam logic [3:0] AOC_OFF_ECHO0  = 4'h9;
  localparam logic [3:0] AOC_OFF_ECHO1  = 4'ha;
  localparam logic [3:0] AOC_OFF_MODE   = 4'hb;

  // Value word layout
  localparam int unsigned AOC_VAL_LSB  = 7;
  localparam int unsigned AOC_VAL_MSB  = 14;
  localparam int unsigned AOC_SIGN_BIT = 15;
  localparam logic [15:0] AOC_VALID_MASK = 16'h7f80;

  // Setup word fields
  localparam int unsigned AOC_B_FAULTSEL  = 0;
  localparam int unsigned AOC_B_IDLESEL   = 2;
  localparam int unsigned AOC_B_FLTSEL    = 3;
  localparam int unsigned AOC_B_INON_LSB  = 4;
  localparam int unsigned AOC_B_OUTON     = 4;
  localparam logic [15:0] AOC_SETUP0_USED = 16'h00fd;
  localparam logic [15:0] AOC_SETUP1_USED = 16'h003d;
  localparam logic [15:0] AOC_SETUP0_RST  = 16'h00f0;
  localparam logic [15:0] AOC_SETUP1_RST  = 16'h0030;
  localparam logic [15:0] AOC_WORD_ZERO   = 16'h0000;

  // Status word bits
  localparam int unsigned AOC_B_BAD0   = 2;
  localparam int unsigned AOC_B_BAD1   = 3;
  localparam int unsigned AOC_B_CFGERR = 8;
  localparam int unsigned AOC_B_HOLD0  = 12;
  localparam int unsigned AOC_B_HOLD1  = 14;

  // System modes
  typedef enum logic [1:0] {
    AOC_RUN   = 2'b00,
    AOC_IDLE  = 2'b01,
    AOC_FAULT = 2'b10
  } aoc_mode_t;

  // Per-channel output source
  typedef enum logic [1:0] {
    AOC_SRC_DATA = 2'b00,
    AOC_SRC_HOLD = 2'b01,
    AOC_SRC_IDLE = 2'b10,
    AOC_SRC_FLT  = 2'b11
  } aoc_src_t;

endpackage

//--- design/aoc_value_check.sv
// Checks one 16-bit value word for the left-justified 8-bit layout.
// Pure combinational; used on output words and safe value words.
`timescale 1ns/1ns
module aoc_value_check (
  // Word under test
  input  wire logic [15:0] word,
  // Verdict and extracted value
  output logic             bad,
  output logic [7:0]       value
);
  import aoc_pkg::*;

  // Any bit outside 14..7, sign included, marks the word bad
  assign bad   = |(word & ~AOC_VALID_MASK);
  assign value = word[AOC_VAL_MSB:AOC_VAL_LSB];
endmodule

//--- design/aoc_channel.sv
// One output channel: picks source by mode and drives the converter code.
// Expects validated values and a mode from the same clock domain.
`timescale 1ns/1ns
module aoc_channel (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Mode and setup
  input  wire aoc_pkg::aoc_mode_t mode,
  input  wire logic             chan_on,
  input  wire logic             idle_sel,
  input  wire logic             fault_sel,
  input  wire logic             idle_to_fault,
  // Values
  input  wire logic [7:0]       data_val,
  input  wire logic [7:0]       idle_val,
  input  wire logic [7:0]       fault_val,
  // Converter side
  output logic [7:0]            dac_code,
  output logic                  dac_on,
  output logic                  holding
);
  import aoc_pkg::*;

  aoc_mode_t prev_r;
  aoc_src_t  src_r;
  aoc_src_t  src_nxt;
  logic [7:0] code_r;

  always_ff @(posedge clock) begin
    if (reset) prev_r <= AOC_RUN;
    else       prev_r <= mode;
  end

  // Source chosen once per mode change, kept until the next
  always_comb begin
    src_nxt = src_r;
    if (mode != prev_r) begin
      case (mode)
        AOC_RUN:  src_nxt = AOC_SRC_DATA;
        AOC_IDLE: src_nxt = idle_sel ? AOC_SRC_IDLE : AOC_SRC_HOLD;
        AOC_FAULT: begin
          if (prev_r == AOC_IDLE && !idle_to_fault)
            src_nxt = src_r;
          else if (fault_sel)
            src_nxt = AOC_SRC_FLT;
          else
            src_nxt = AOC_SRC_HOLD;
        end
        default:  src_nxt = AOC_SRC_HOLD;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) src_r <= AOC_SRC_DATA;
    else       src_r <= src_nxt;
  end

  // Zero safe value gives minimum output; hold keeps code_r
  always_ff @(posedge clock) begin
    if (reset) code_r <= 8'h00;
    else begin
      case (src_nxt)
        AOC_SRC_DATA: code_r <= data_val;
        AOC_SRC_IDLE: code_r <= idle_val;
        AOC_SRC_FLT:  code_r <= fault_val;
        AOC_SRC_HOLD: code_r <= code_r;
        default:      code_r <= code_r;
      endcase
    end
  end

  assign dac_code = chan_on ? code_r : 8'h00;
  assign dac_on   = chan_on;
  assign holding  = (src_r == AOC_SRC_HOLD);
endmodule

//--- design/aoc_top.sv
// Output word and mode control: register file, word checks, two channels.
// Assumes a one-cycle strobe register port and system mode from the same clock.
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Value sits in bits 14..7, LSB bit 7
// - Bad bits in output word raise flag
// - Bad output word keeps last accepted value
// - Setup0 bits 4..7 enable input channels
// - Disabled input channel reports no value
// - Setup1 bits 4,5 enable outputs; off drives none
// - Ones in unused setup fields flag error
// - Idle select at bit 2 of setups
// - Idle select zero holds last value
// - Idle select one converts idle value
// - Fault select bit 3; clear holds
// - Fault select one converts fault value
// - Fault value zero gives range minimum
// - Both selects default to zero, hold
// - Bit 0 picks value on idle-to-fault
// - Bad safe value raises configuration error
// - Bad output flags in status bits 2,3
module aoc_top #(
  parameter int unsigned NUM_IN = aoc_pkg::AOC_NIN
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // Register port
  input  wire logic [aoc_pkg::AOC_ADDR_W-1:0] addr,
  input  wire logic [aoc_pkg::AOC_WORD_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic [aoc_pkg::AOC_WORD_W-1:0] rdata,
  // System mode
  input  wire aoc_pkg::aoc_mode_t        sys_mode,
  // Measured input words from the converter
  input  wire logic [NUM_IN*aoc_pkg::AOC_WORD_W-1:0] in_meas,
  output logic [NUM_IN*aoc_pkg::AOC_WORD_W-1:0]      in_report,
  output logic [NUM_IN-1:0]              input_chan_on,
  // Output converters
  output logic [aoc_pkg::AOC_VAL_W-1:0]  dac_code0,
  output logic [aoc_pkg::AOC_VAL_W-1:0]  dac_code1,
  output logic [1:0]                     output_chan_on,
  // Status
  output logic                           config_error
);
  import aoc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] out0_r, out1_r, setup0_r, setup1_r;
  logic [15:0] flt0_r, idle0_r, flt1_r, idle1_r;
  logic [7:0]  acc0_r, acc1_r;
  logic [1:0]  bad_output_flag_r;
  logic        cfg_err_r;
  logic [15:0] rdata_r;
  logic [NUM_IN*AOC_WORD_W-1:0] in_rep_r;

  logic        bad_w, bad_o0, bad_o1, bad_f0, bad_i0, bad_f1, bad_i1;
  logic [7:0]  val_w, val_f0, val_i0, val_f1, val_i1;
  logic        hold0, hold1, on0, on1;
  logic        wr_out0, wr_out1;

  assign wr_out0 = wr && (addr == AOC_OFF_OUT0);
  assign wr_out1 = wr && (addr == AOC_OFF_OUT1);

  //////////////////////////////////////////////////////////////////////////////
  // Word checks
  aoc_value_check u_chk_w (
    .word  (wdata),
    .bad   (bad_w),
    .value (val_w)
  );
  aoc_value_check u_chk_f0 (
    .word  (flt0_r),
    .bad   (bad_f0),
    .value (val_f0)
  );
  aoc_value_check u_chk_i0 (
    .word  (idle0_r),
    .bad   (bad_i0),
    .value (val_i0)
  );
  aoc_value_check u_chk_f1 (
    .word  (flt1_r),
    .bad   (bad_f1),
    .value (val_f1)
  );
  aoc_value_check u_chk_i1 (
    .word  (idle1_r),
    .bad   (bad_i1),
    .value (val_i1)
  );
  assign bad_o0 = wr_out0 && bad_w;
  assign bad_o1 = wr_out1 && bad_w;

  //////////////////////////////////////////////////////////////////////////////
  // Output data words: stored as written, echo shows the driven converter code
  always_ff @(posedge clock) begin
    if (reset) begin
      out0_r <= AOC_WORD_ZERO;
      out1_r <= AOC_WORD_ZERO;
    end else begin
      if (wr_out0) out0_r <= wdata;
      if (wr_out1) out1_r <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      acc0_r <= 8'h00;
      acc1_r <= 8'h00;
    end else begin
      if (wr_out0 && !bad_w) acc0_r <= val_w;
      if (wr_out1 && !bad_w) acc1_r <= val_w;
    end
  end

  // Flag is a level per last write; a good write clears it
  always_ff @(posedge clock) begin
    if (reset) bad_output_flag_r <= 2'b00;
    else begin
      if (wr_out0) bad_output_flag_r[0] <= bad_o0;
      if (wr_out1) bad_output_flag_r[1] <= bad_o1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Setup and safe value words
  always_ff @(posedge clock) begin
    if (reset) begin
      setup0_r <= AOC_SETUP0_RST;
      setup1_r <= AOC_SETUP1_RST;
      flt0_r   <= AOC_WORD_ZERO;
      idle0_r  <= AOC_WORD_ZERO;
      flt1_r   <= AOC_WORD_ZERO;
      idle1_r  <= AOC_WORD_ZERO;
    end else if (wr) begin
      case (addr)
        AOC_OFF_SETUP0: setup0_r <= wdata;
        AOC_OFF_SETUP1: setup1_r <= wdata;
        AOC_OFF_FLT0:   flt0_r   <= wdata;
        AOC_OFF_IDLE0:  idle0_r  <= wdata;
        AOC_OFF_FLT1:   flt1_r   <= wdata;
        AOC_OFF_IDLE1:  idle1_r  <= wdata;
        default: ;
      endcase
    end
  end

  // Unused setup bits or badly formed safe values
  always_ff @(posedge clock) begin
    if (reset) cfg_err_r <= 1'b0;
    else cfg_err_r <= (|(setup0_r & ~AOC_SETUP0_USED))
                   || (|(setup1_r & ~AOC_SETUP1_USED))
                   || bad_f0 || bad_i0 || bad_f1 || bad_i1;
  end
  assign config_error = cfg_err_r;

  //////////////////////////////////////////////////////////////////////////////
  // Input channel enables and reporting
  assign input_chan_on = setup0_r[AOC_B_INON_LSB +: NUM_IN];

  always_ff @(posedge clock) begin
    if (reset) in_rep_r <= '0;
    else begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_rep_r[i*AOC_WORD_W +: AOC_WORD_W] <= input_chan_on[i]
          ? in_meas[i*AOC_WORD_W +: AOC_WORD_W] : AOC_WORD_ZERO;
      end
    end
  end
  assign in_report = in_rep_r;

  //////////////////////////////////////////////////////////////////////////////
  // Output channels
  aoc_channel u_ch0 (
    .clock         (clock),
    .reset         (reset),
    .mode          (sys_mode),
    .chan_on       (setup1_r[AOC_B_OUTON]),
    .idle_sel      (setup0_r[AOC_B_IDLESEL]),
    .fault_sel     (setup0_r[AOC_B_FLTSEL]),
    .idle_to_fault (setup0_r[AOC_B_FAULTSEL]),
    .data_val      (wr_out0 && !bad_w ? val_w : acc0_r),
    .idle_val      (val_i0),
    .fault_val     (val_f0),
    .dac_code      (dac_code0),
    .dac_on        (on0),
    .holding       (hold0)
  );
  aoc_channel u_ch1 (
    .clock         (clock),
    .reset         (reset),
    .mode          (sys_mode),
    .chan_on       (setup1_r[AOC_B_OUTON+1]),
    .idle_sel      (setup1_r[AOC_B_IDLESEL]),
    .fault_sel     (setup1_r[AOC_B_FLTSEL]),
    .idle_to_fault (setup1_r[AOC_B_FAULTSEL]),
    .data_val      (wr_out1 && !bad_w ? val_w : acc1_r),
    .idle_val      (val_i1),
    .fault_val     (val_f1),
    .dac_code      (dac_code1),
    .dac_on        (on1),
    .holding       (hold1)
  );
  assign output_chan_on = {on1, on0};

  //////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clock) begin
    if (reset) rdata_r <= AOC_WORD_ZERO;
    else if (rd) begin
      rdata_r <= AOC_WORD_ZERO;
      case (addr)
        AOC_OFF_OUT0:   rdata_r <= out0_r;
        AOC_OFF_OUT1:   rdata_r <= out1_r;
        AOC_OFF_SETUP0: rdata_r <= setup0_r;
        AOC_OFF_SETUP1: rdata_r <= setup1_r;
        AOC_OFF_FLT0:   rdata_r <= flt0_r;
        AOC_OFF_IDLE0:  rdata_r <= idle0_r;
        AOC_OFF_FLT1:   rdata_r <= flt1_r;
        AOC_OFF_IDLE1:  rdata_r <= idle1_r;
        AOC_OFF_STATUS: begin
          rdata_r[AOC_B_BAD0]   <= bad_output_flag_r[0];
          rdata_r[AOC_B_BAD1]   <= bad_output_flag_r[1];
          rdata_r[AOC_B_CFGERR] <= cfg_err_r;
          rdata_r[AOC_B_HOLD0]  <= hold0;
          rdata_r[AOC_B_HOLD1]  <= hold1;
        end
        AOC_OFF_ECHO0:  rdata_r[AOC_VAL_MSB:AOC_VAL_LSB] <= dac_code0;
        AOC_OFF_ECHO1:  rdata_r[AOC_VAL_MSB:AOC_VAL_LSB] <= dac_code1;
        AOC_OFF_MODE:   rdata_r[1:0] <= sys_mode;
        default: ;
      endcase
    end else rdata_r <= AOC_WORD_ZERO;
  end
  assign rdata = rdata_r;
endmodule

//--- dv/aoc_monitor.sv
// Checker on the ports of aoc_top, bound after the module.
// Assumes one clock; shadows the channel 0 setup and safe words.
`timescale 1ns/1ns
module aoc_monitor #(
  parameter int unsigned NUM_IN = aoc_pkg::AOC_NIN
) (
  // Clock and reset
  input wire logic                                  clock,
  input wire logic                                  reset,
  // Register port
  input wire logic [aoc_pkg::AOC_ADDR_W-1:0]        addr,
  input wire logic [aoc_pkg::AOC_WORD_W-1:0]        wdata,
  input wire logic                                  wr,
  input wire logic                                  rd,
  input wire logic [aoc_pkg::AOC_WORD_W-1:0]        rdata,
  // Mode and channels
  input wire aoc_pkg::aoc_mode_t                    sys_mode,
  input wire logic [NUM_IN*aoc_pkg::AOC_WORD_W-1:0] in_meas,
  input wire logic [NUM_IN*aoc_pkg::AOC_WORD_W-1:0] in_report,
  input wire logic [NUM_IN-1:0]                     input_chan_on,
  input wire logic [aoc_pkg::AOC_VAL_W-1:0]         dac_code0,
  input wire logic [aoc_pkg::AOC_VAL_W-1:0]         dac_code1,
  input wire logic [1:0]                            output_chan_on,
  input wire logic                                  config_error
);
  import aoc_pkg::*;
  logic [15:0] setup0_r;
  logic [7:0]  idle0_r;
  logic [7:0]  flt0_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      setup0_r <= AOC_SETUP0_RST;
      idle0_r  <= 8'h00;
      flt0_r   <= 8'h00;
    end else if (wr) begin
      if (addr == AOC_OFF_SETUP0) setup0_r <= wdata;
      if (addr == AOC_OFF_IDLE0) idle0_r <= wdata[14:7];
      if (addr == AOC_OFF_FLT0) flt0_r <= wdata[14:7];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_good0;
    wr && addr == AOC_OFF_OUT0 && (wdata & ~AOC_VALID_MASK) == 16'h0000;
  endsequence
  sequence s_bad0;
    wr && addr == AOC_OFF_OUT0 && (wdata & ~AOC_VALID_MASK) != 16'h0000;
  endsequence
  sequence s_quiet;
    !wr && sys_mode == AOC_RUN && output_chan_on[0];
  endsequence
  a_run_tracks: assert property (
    s_good0 ##1 s_quiet |-> ##1 dac_code0 == $past(wdata[14:7], 2))
    else $error("dac_code0 does not follow output word");
  // Compares the code before and after the rejected write's own edge
  a_bad_keeps: assert property (
    s_bad0 ##0 (sys_mode == AOC_RUN && $past(sys_mode) == AOC_RUN && output_chan_on[0])
    |=> $stable(dac_code0))
    else $error("dac_code0 took a rejected word");
  a_off_zero: assert property (
    !output_chan_on[0] && $past(!output_chan_on[0]) |-> dac_code0 == 8'h00)
    else $error("disabled output drives a code");
  a_in_gate: assert property (
    !input_chan_on[0] |=> in_report[15:0] == 16'h0000)
    else $error("disabled input reports a value");
  a_cfg_unused: assert property (
    wr && addr == AOC_OFF_SETUP0 && (wdata & ~AOC_SETUP0_USED) != 16'h0000
    |-> ##[1:2] config_error)
    else $error("unused setup bit not flagged");
  a_cfg_safe: assert property (
    wr && addr == AOC_OFF_FLT0 && (wdata & ~AOC_VALID_MASK) != 16'h0000
    |-> ##[1:2] config_error)
    else $error("bad safe value not flagged");
  a_idle_value: assert property (
    sys_mode == AOC_IDLE && $past(sys_mode) == AOC_RUN && !wr
    && setup0_r[AOC_B_IDLESEL] && output_chan_on[0] |=> dac_code0 == idle0_r)
    else $error("idle value not applied");
  a_idle_hold: assert property (
    sys_mode == AOC_IDLE && $past(sys_mode) == AOC_RUN && !wr
    && !setup0_r[AOC_B_IDLESEL] |=> $stable(dac_code0))
    else $error("idle hold lost the last code");
  a_flt_value: assert property (
    sys_mode == AOC_FAULT && $past(sys_mode) == AOC_RUN && !wr
    && setup0_r[AOC_B_FLTSEL] && output_chan_on[0] |=> dac_code0 == flt0_r)
    else $error("fault value not applied");
endmodule
bind aoc_top aoc_monitor #(.NUM_IN(NUM_IN)) aoc_monitor_i (
  .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sys_mode(sys_mode), .in_meas(in_meas), .in_report(in_report),
  .input_chan_on(input_chan_on), .dac_code0(dac_code0), .dac_code1(dac_code1),
  .output_chan_on(output_chan_on), .config_error(config_error)
);

//--- dv/aoc_host_model.sv
// Host controller model: master on the word register port.
// Assumes read data one cycle after the read strobe, no waits.
`timescale 1ns/1ns
module aoc_host_model (
  // Clock
  input  wire logic        clock,
  // Register port
  output logic [3:0]       addr,
  output logic [15:0]      wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  initial begin
    addr  = 4'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  task automatic wr_word(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
  // Masked move: sign and low bits always written as zero
  task automatic put_val(input logic [3:0] a, input logic [7:0] v);
    wr_word(a, {1'b0, v, 7'h00});
  endtask
  task automatic rd_word(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

//--- dv/test_aoc_top.sv
// Self-checking bench for aoc_top against a behavioural model.
// Assumes the host model and the bound checker are compiled.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  mismatches++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_aoc_top;
  import aoc_pkg::*;
  logic        clock, reset, wr, rd, config_error;
  logic [3:0]  addr, input_chan_on;
  logic [15:0] wdata, rdata, d, mb;
  logic [63:0] in_meas, in_report;
  logic [7:0]  dac_code0, dac_code1;
  logic [1:0]  output_chan_on;
  aoc_mode_t   sys_mode, mode_m;
  logic [15:0] s[2];
  logic [1:0]  hl;
  int          ov[2], iv[2], fv[2], cur[2];
  int          mismatches, samples_checked, cycles;
  logic [3:0]  ea[4] = '{AOC_OFF_SETUP0, AOC_OFF_SETUP1, AOC_OFF_FLT0, AOC_OFF_IDLE1};
  logic [15:0] ew[4] = '{16'h00f2, 16'h0130, 16'h0001, 16'h8000};
  logic [15:0] er[4] = '{AOC_SETUP0_RST, AOC_SETUP1_RST, 16'h0000, 16'h0000};
  aoc_top aoc_top_i (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sys_mode(sys_mode), .in_meas(in_meas), .in_report(in_report),
    .input_chan_on(input_chan_on), .dac_code0(dac_code0), .dac_code1(dac_code1),
    .output_chan_on(output_chan_on), .config_error(config_error));
  aoc_host_model aoc_host_model_i (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task chk_dac;
    `CHK("dac_code0", s[1][4] ? cur[0] : 0, dac_code0)
    `CHK("dac_code1", s[1][5] ? cur[1] : 0, dac_code1)
  endtask
  task put(input int c, input int v);
    aoc_host_model_i.put_val(c ? AOC_OFF_OUT1 : AOC_OFF_OUT0, v[7:0]);
    ov[c] = v;
    if (mode_m == AOC_RUN) cur[c] = v;
    settle;
    chk_dac;
  endtask
  task setw(input logic [3:0] a, input logic [15:0] w);
    aoc_host_model_i.wr_word(a, w);
    case (a)
      AOC_OFF_SETUP0: s[0] = w;
      AOC_OFF_SETUP1: s[1] = w;
      AOC_OFF_FLT0:   fv[0] = w[14:7];
      AOC_OFF_IDLE0:  iv[0] = w[14:7];
      AOC_OFF_FLT1:   fv[1] = w[14:7];
      default:        iv[1] = w[14:7];
    endcase
    settle;
    aoc_host_model_i.rd_word(a, d);
    `CHK("readback", w, d)
  endtask
  task go(input aoc_mode_t m);
    for (int c = 0; c < 2; c++) begin
      if (m == AOC_RUN) cur[c] = ov[c];
      else if (m == AOC_IDLE && s[c][AOC_B_IDLESEL]) cur[c] = iv[c];
      else if (m == AOC_FAULT && s[c][AOC_B_FLTSEL]
               && (mode_m != AOC_IDLE || s[c][AOC_B_FAULTSEL])) cur[c] = fv[c];
      // Hold flag follows the source picked at mode entry
      if (m == AOC_RUN) hl[c] = 1'b0;
      else if (m == AOC_IDLE) hl[c] = !s[c][AOC_B_IDLESEL];
      else if (mode_m != AOC_IDLE || s[c][AOC_B_FAULTSEL]) hl[c] = !s[c][AOC_B_FLTSEL];
    end
    mode_m = m;
    @(posedge clock);
    sys_mode <= m;
    repeat (3) @(posedge clock);
    #1 chk_dac;
    aoc_host_model_i.rd_word(AOC_OFF_ECHO0, d);
    `CHK("echo0", 16'((s[1][4] ? cur[0] : 0) << 7), d)
    aoc_host_model_i.rd_word(AOC_OFF_ECHO1, d);
    `CHK("echo1", 16'((s[1][5] ? cur[1] : 0) << 7), d)
    aoc_host_model_i.rd_word(AOC_OFF_STATUS, d);
    `CHK("hold0", hl[0], d[AOC_B_HOLD0])
    `CHK("hold1", hl[1], d[AOC_B_HOLD1])
  endtask
  initial begin
    reset = 1'b1;
    sys_mode = AOC_RUN;
    mode_m = AOC_RUN;
    hl = 2'b00;
    in_meas = '0;
    s[0] = AOC_SETUP0_RST;
    s[1] = AOC_SETUP1_RST;
    void'($urandom(32'ha1ade626));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    in_meas <= {$urandom, $urandom};
    for (logic [3:0] a = 4'h2; a < 4'h8; a++) begin
      aoc_host_model_i.rd_word(a, d);
      `CHK("reset word", a == 4'h2 ? 16'h00f0 : a == 4'h3 ? 16'h0030 : 16'h0000, d)
    end
    aoc_host_model_i.rd_word(4'hc, d);
    `CHK("unmapped", 16'h0000, d)
    repeat (8) put($urandom_range(1, 0), $urandom_range(255, 0));
    // Every forbidden bit, alternating channels
    for (int b = 0; b < 16; b++) if (!AOC_VALID_MASK[b]) begin
      aoc_host_model_i.wr_word(b % 2 ? AOC_OFF_OUT1 : AOC_OFF_OUT0, 16'h2d00 | 16'(1 << b));
      settle;
      chk_dac;
      aoc_host_model_i.rd_word(AOC_OFF_STATUS, d);
      `CHK("bad flag", 1'b1, d[AOC_B_BAD0 + b % 2])
      put(b % 2, b * 8);
      aoc_host_model_i.rd_word(AOC_OFF_STATUS, d);
      `CHK("bad flag clear", 1'b0, d[AOC_B_BAD0 + b % 2])
    end
    setw(AOC_OFF_SETUP0, 16'h00a0);
    `CHK("input_chan_on", 4'ha, input_chan_on)
    for (int c = 0; c < 4; c++) begin
      `CHK("in_report", s[0][4+c] ? in_meas[16*c +: 16] : 16'h0000, in_report[16*c +: 16])
    end
    setw(AOC_OFF_SETUP1, 16'h0020);
    chk_dac;
    `CHK("output_chan_on", 2'b10, output_chan_on)
    for (int i = 0; i < 4; i++) begin
      setw(ea[i], ew[i]);
      `CHK("config_error set", 1'b1, config_error)
      setw(ea[i], er[i]);
      `CHK("config_error clear", 1'b0, config_error)
    end
    for (int k = 0; k < 8; k++) begin
      mb = {12'h000, k[2], k[1], 1'b0, k[0]};
      setw(AOC_OFF_SETUP0, AOC_SETUP0_RST | mb);
      setw(AOC_OFF_SETUP1, AOC_SETUP1_RST | mb);
      setw(AOC_OFF_IDLE0, 16'($urandom) & AOC_VALID_MASK);
      setw(AOC_OFF_FLT0, AOC_WORD_ZERO);
      setw(AOC_OFF_IDLE1, 16'($urandom) & AOC_VALID_MASK);
      setw(AOC_OFF_FLT1, 16'($urandom) & AOC_VALID_MASK);
      put(0, $urandom_range(255, 1));
      put(1, $urandom_range(255, 1));
      go(AOC_IDLE);
      go(AOC_FAULT);
      go(AOC_RUN);
      go(AOC_FAULT);
      go(AOC_RUN);
    end
    complete_run;
  end
endmodule
